// file: logic/pdg_defs.svh
// Constants of the duty-cycle generator: register indexes, field positions, reset values, timing.
// How it works
// - The duty setting has ten bits of resolution.
// - The duty value is the duty master byte as its upper eight bits over mode control bits 5:4 as its lower two.
// - Duty master bits may be written at any time and reach the duty slave only at a period match.
// - In pulse-width mode software writes to the duty slave register are ignored.
// - The duty slave register and a 2-bit latch double-buffer the duty so a period never glitches.
// - The pin is cleared when slave and latch equal the timer extended by two sub-cycle bits.
// - A duty larger than the period never clears the pin in that period.
// - High time is the duty value times the core clock period times the prescale factor.
// - Prescale factors of 1, 4 or 16 are selectable and scale both period and duty.
`ifndef PDG_DEFS_SVH
`define PDG_DEFS_SVH

// ==========================================================
// Register indexes (byte address is four times the index)
`define PDG_IDX_TIMER 10'h011
`define PDG_IDX_TCTL 10'h012
`define PDG_IDX_MASTER 10'h015
`define PDG_IDX_SLAVE 10'h016
`define PDG_IDX_MODE 10'h017
`define PDG_IDX_PERIOD 10'h092
`define PDG_IDX_STATUS 10'h020

// ==========================================================
// Field positions
`define PDG_TCTL_PS_HI 1
`define PDG_TCTL_PS_LO 0
`define PDG_TCTL_ON 2
`define PDG_TCTL_POST_HI 6
`define PDG_TCTL_POST_LO 3
`define PDG_MODE_DLO_HI 5
`define PDG_MODE_DLO_LO 4
`define PDG_MODE_PWM_HI 3
`define PDG_MODE_PWM_LO 2
`define PDG_MODE_PWM_CODE 2'h3
`define PDG_STAT_MATCH 0

// ==========================================================
// Reset values
`define PDG_RST_TIMER 8'h00
`define PDG_RST_TCTL 7'h00
`define PDG_RST_MASTER 8'h00
`define PDG_RST_SLAVE 8'h00
`define PDG_RST_MODE 6'h00
`define PDG_RST_PERIOD 8'hff

// ==========================================================
// Timing: core clock phases per timer input cycle
`define PDG_Q_PHASES 3'h4

`endif

// file: logic/pdg_pkg.sv
// Types and shared decode of the duty-cycle generator.
package pdg_pkg;

  typedef enum logic [1:0] {pdg_div1, pdg_div4, pdg_div16} pdg_div_t;

  function automatic pdg_div_t pdg_div_decode(input logic [1:0] sel);
    pdg_div_t d;
    if (sel == 2'h0)
      d = pdg_div1;
    else if (sel == 2'h1)
      d = pdg_div4;
    else
      d = pdg_div16;
    return d;
  endfunction

  function automatic logic [4:0] pdg_div_factor(input pdg_div_t d);
    logic [4:0] f;
    case (d)
      pdg_div1: f = 5'h01;
      pdg_div4: f = 5'h04;
      default: f = 5'h10;
    endcase
    return f;
  endfunction

endpackage

// file: logic/pdg_prescale.sv
// Phase counter and timer prescaler producing the timer tick and the two sub-cycle bits.
`timescale 1ns/1ps
`include "pdg_defs.svh"
module pdg_prescale
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic clr,
  input wire pdg_pkg::pdg_div_t div,
  output logic tick,
  output logic [1:0] sub_bits
);
  import pdg_pkg::*;

  logic [1:0] q_phase;
  logic [3:0] pre;
  logic [3:0] pre_top;
  logic q_last;
  logic [3:0] pre_ahead;

  // ==========================================================
  // Decode
  assign q_last = (q_phase == 2'(`PDG_Q_PHASES - 3'h1));
  assign pre_top = (div == pdg_div1) ? 4'h0 : (div == pdg_div4) ? 4'h3 : 4'hf;
  assign tick = run && q_last && (pre == pre_top);
  // Finest steps of the compare: core phases at 1:1, prescaler bits otherwise.
  // They are the bits of the next cycle, as the compare looks one cycle ahead of the pin flop.
  assign pre_ahead = (run && q_last) ? 4'(pre + 4'h1) : pre;
  assign sub_bits = (div == pdg_div1) ? 2'(q_phase + 2'h1) : (div == pdg_div4) ? pre_ahead[1:0] : pre_ahead[3:2];

  // ==========================================================
  // Counters
  always_ff @(posedge core_clk)
  begin
    if (srst)
      q_phase <= 2'h0;
    else
      q_phase <= q_phase + 2'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || clr)
      pre <= 4'h0;
    else if (tick)
      pre <= 4'h0;
    else if (run && q_last)
      pre <= pre + 4'h1;
  end

endmodule

// file: logic/pdg_top.sv
// Pulse-width output stage with period timer, double-buffered duty and APB register slave.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "pdg_defs.svh"
module pdg_top
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pulse_output_pin,
  output logic pulse_output_en
);
  import pdg_pkg::*;

  logic [7:0] period_timer_count;
  logic [6:0] period_timer_control;
  logic [7:0] duty_master_high_bits;
  logic [7:0] duty_slave_value;
  logic [5:0] unit_mode_control;
  logic [7:0] period_compare_value;
  logic [1:0] duty_latch;
  logic [3:0] post_cnt;
  logic period_match_flag;
  logic pin;
  logic [31:0] next_prdata;

  logic setup;
  logic access;
  logic wr;
  logic hit_timer;
  logic hit_tctl;
  logic hit_master;
  logic hit_slave;
  logic hit_mode;
  logic hit_period;
  logic hit_status;
  logic hit_any;
  logic wr_timer;
  logic wr_tctl;
  logic wr_master;
  logic wr_slave;
  logic wr_mode;
  logic wr_period;
  logic wr_status;
  logic pwm_mode;
  logic timer_on;
  pdg_div_t div;
  logic tick;
  logic [1:0] sub_bits;
  logic pend;
  logic post_done;
  logic [9:0] duty_next;
  logic [9:0] duty_live;
  logic [9:0] timer_ext;
  logic [7:0] timer_ahead;
  logic match;

  // ==========================================================
  // APB decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign hit_timer = (paddr == {`PDG_IDX_TIMER, 2'h0});
  assign hit_tctl = (paddr == {`PDG_IDX_TCTL, 2'h0});
  assign hit_master = (paddr == {`PDG_IDX_MASTER, 2'h0});
  assign hit_slave = (paddr == {`PDG_IDX_SLAVE, 2'h0});
  assign hit_mode = (paddr == {`PDG_IDX_MODE, 2'h0});
  assign hit_period = (paddr == {`PDG_IDX_PERIOD, 2'h0});
  assign hit_status = (paddr == {`PDG_IDX_STATUS, 2'h0});
  assign hit_any = hit_timer || hit_tctl || hit_master || hit_slave || hit_mode || hit_period || hit_status;
  assign wr_timer = wr && hit_timer;
  assign wr_tctl = wr && hit_tctl;
  assign wr_master = wr && hit_master;
  assign wr_slave = wr && hit_slave;
  assign wr_mode = wr && hit_mode;
  assign wr_period = wr && hit_period;
  assign wr_status = wr && hit_status;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_timer)
      next_prdata = {24'h00_0000, period_timer_count};
    else if (hit_tctl)
      next_prdata = {25'h000_0000, period_timer_control};
    else if (hit_master)
      next_prdata = {24'h00_0000, duty_master_high_bits};
    else if (hit_slave)
      next_prdata = {24'h00_0000, duty_slave_value};
    else if (hit_mode)
      next_prdata = {26'h000_0000, unit_mode_control};
    else if (hit_period)
      next_prdata = {24'h00_0000, period_compare_value};
    else if (hit_status)
      next_prdata = {31'h0000_0000, period_match_flag};
  end

  // Read data is captured in the setup cycle so it is a flop during access
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= next_prdata;
  end

  // ==========================================================
  // Control decode
  assign pwm_mode = (unit_mode_control[`PDG_MODE_PWM_HI:`PDG_MODE_PWM_LO] == `PDG_MODE_PWM_CODE);
  assign timer_on = period_timer_control[`PDG_TCTL_ON];
  assign div = pdg_div_decode(period_timer_control[`PDG_TCTL_PS_HI:`PDG_TCTL_PS_LO]);
  assign duty_next = {duty_master_high_bits, unit_mode_control[`PDG_MODE_DLO_HI:`PDG_MODE_DLO_LO]};
  assign duty_live = {duty_slave_value, duty_latch};
  // The pin is a flop: compare against the next cycle's timer so the pin falls as the match begins
  assign timer_ahead = tick ? 8'(period_timer_count + 8'h01) : period_timer_count;
  assign timer_ext = {timer_ahead, sub_bits};
  assign pend = tick && (period_timer_count == period_compare_value);
  assign match = (duty_live == timer_ext);
  assign post_done = pend && (post_cnt == period_timer_control[`PDG_TCTL_POST_HI:`PDG_TCTL_POST_LO]);
  assign pulse_output_pin = pin;
  assign pulse_output_en = pwm_mode;

  // ==========================================================
  // Prescaler; a write to the timer restarts it
  pdg_prescale u_prescale
  (
    .core_clk(core_clk),
    .srst(srst),
    .run(timer_on),
    .clr(wr_timer),
    .div(div),
    .tick(tick),
    .sub_bits(sub_bits)
  );

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
      period_timer_count <= `PDG_RST_TIMER;
    else if (wr_timer)
      period_timer_count <= pwdata[7:0];
    else if (pend)
      period_timer_count <= 8'h00;
    else if (tick)
      period_timer_count <= period_timer_count + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      period_timer_control <= `PDG_RST_TCTL;
      duty_master_high_bits <= `PDG_RST_MASTER;
      unit_mode_control <= `PDG_RST_MODE;
      period_compare_value <= `PDG_RST_PERIOD;
    end
    else
    begin
      if (wr_tctl)
        period_timer_control <= pwdata[6:0];
      if (wr_master)
        duty_master_high_bits <= pwdata[7:0];
      if (wr_mode)
        unit_mode_control <= pwdata[5:0];
      if (wr_period)
        period_compare_value <= pwdata[7:0];
    end
  end

  // In pulse-width mode slave and latch change only at a period end, so a period never sees a half-updated duty
  always_ff @(posedge core_clk)
  begin
    if (srst)
      duty_slave_value <= `PDG_RST_SLAVE;
    else if (pwm_mode && pend)
      duty_slave_value <= duty_master_high_bits;
    else if (wr_slave && !pwm_mode)
      duty_slave_value <= pwdata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      duty_latch <= 2'h0;
    else if (pwm_mode && pend)
      duty_latch <= unit_mode_control[`PDG_MODE_DLO_HI:`PDG_MODE_DLO_LO];
  end

  // Period end outranks the compare so a duty equal to the whole period still keeps the pin high
  always_ff @(posedge core_clk)
  begin
    if (srst)
      pin <= 1'b0;
    else if (!pwm_mode)
      pin <= 1'b0;
    else if (pend)
      pin <= (duty_next != 10'h000);
    else if (match)
      pin <= 1'b0;
  end

  // Postscaler and sticky match flag; a new match wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst || wr_tctl)
      post_cnt <= 4'h0;
    else if (post_done)
      post_cnt <= 4'h0;
    else if (pend)
      post_cnt <= post_cnt + 4'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      period_match_flag <= 1'b0;
    else if (post_done)
      period_match_flag <= 1'b1;
    else if (wr_status && !pwdata[`PDG_STAT_MATCH])
      period_match_flag <= 1'b0;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic [6:0] gap_cnt;
  logic tick_seen;
  logic cfg_dirty;
  logic [14:0] hi_cnt;
  logic hi_clean;
  logic [6:0] gap_expect;
  logic [14:0] hi_expect;
  logic any_wr;

  assign any_wr = wr;
  assign gap_expect = 7'({pdg_div_factor(div), 2'h0} - 7'h01);
  assign hi_expect = 15'(duty_live * pdg_div_factor(div));

  always_ff @(posedge core_clk)
  begin
    if (srst || tick)
      gap_cnt <= 7'h00;
    else
      gap_cnt <= gap_cnt + 7'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      tick_seen <= 1'b0;
    else if (tick)
      tick_seen <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      cfg_dirty <= 1'b1;
    else if (wr_tctl || wr_timer)
      cfg_dirty <= 1'b1;
    else if (tick)
      cfg_dirty <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || !pin)
      hi_cnt <= 15'h0000;
    else
      hi_cnt <= hi_cnt + 15'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || any_wr)
      hi_clean <= 1'b0;
    else if (pwm_mode && pend)
      hi_clean <= 1'b1;
  end

  sequence s_period_end;
    pwm_mode && pend && !any_wr;
  endsequence

  sequence s_restart;
    pin && (period_timer_count == 8'h00);
  endsequence

  sequence s_mid_period;
    pwm_mode && !pend && !any_wr;
  endsequence

  AST_DUTY_LOAD: assert property (s_period_end |=> duty_live == $past(duty_next))
    else $error("duty not loaded at period end");
  AST_SLAVE_RO: assert property (pwm_mode && wr_slave && !pend |=> $stable(duty_slave_value))
    else $error("duty slave changed by write in pwm mode");
  AST_LATCH_HOLD: assert property (!(pwm_mode && pend) |=> $stable(duty_latch))
    else $error("low duty latch changed inside a period");
  AST_CLEAR: assert property (pwm_mode && match && !pend && !any_wr |=> !pin)
    else $error("pin not cleared on duty match");
  AST_NO_CLEAR: assert property (pwm_mode && pin && !pend && !any_wr && (period_timer_count <= period_compare_value)
    && (duty_live > {period_compare_value, 2'h3}) |=> pin)
    else $error("pin cleared although duty exceeds period");
  // A write inside the pulse or on its last edge voids the measurement
  AST_HIGH_TIME: assert property ($fell(pin) && hi_clean && $past(pwm_mode) && (duty_live != 10'h000)
    |-> hi_cnt == hi_expect)
    else $error("high time differs from duty times prescale");
  AST_TICK_GAP: assert property (tick && tick_seen && !cfg_dirty |-> gap_cnt == gap_expect)
    else $error("timer tick spacing wrong for prescale");
  AST_RESTART: assert property (s_period_end ##0 (duty_next != 10'h000) |=> s_restart)
    else $error("period end did not restart timer and raise pin");

  // Timer stepping, slave and pin stability inside a period and the match flag
  AST_SLAVE_HOLD: assert property (s_mid_period |=> $stable(duty_slave_value))
    else $error("duty slave changed inside a period");
  AST_PIN_HOLD: assert property (s_mid_period ##0 !pin |=> !pin)
    else $error("pin rose inside a period");
  AST_ZERO_DUTY: assert property (s_period_end ##0 (duty_next == 10'h000) |=> !pin)
    else $error("pin raised although the new duty is zero");
  AST_STOPPED: assert property (!timer_on |-> !tick)
    else $error("timer ticked while disabled");
  AST_TIMER_STEP: assert property (tick && !pend && !wr_timer
    |=> period_timer_count == 8'($past(period_timer_count) + 8'h01))
    else $error("timer did not step on tick");
  AST_TIMER_HOLD: assert property (!tick && !wr_timer |=> $stable(period_timer_count))
    else $error("timer moved without a tick");
  AST_FLAG_SET: assert property (post_done |=> period_match_flag)
    else $error("match flag not set at period match");

endmodule

// file: sim/pdg_pin_monitor.sv
// Far-side load on the pulse pin: measures the last high time and the rise-to-rise period.
`timescale 1ns/1ps
module pdg_pin_monitor
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pin,
  input wire logic en,
  output logic [15:0] last_high,
  output logic [15:0] last_period
);
  logic pin_q;
  logic [15:0] hi_cnt;
  logic [15:0] since_rise;
  // ==========================================
  // Pulse measurement
  // Only a driven pin counts; an undriven pin reads as low here
  wire lvl = pin & en;
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_q <= 1'b0;
      hi_cnt <= 16'h0000;
      since_rise <= 16'h0000;
      last_high <= 16'h0000;
      last_period <= 16'h0000;
    end
    else
    begin
      pin_q <= lvl;
      if (lvl && !pin_q)
      begin
        last_period <= since_rise;
        since_rise <= 16'h0001;
        hi_cnt <= 16'h0001;
      end
      else
      begin
        since_rise <= since_rise + 16'h0001;
        if (lvl)
          hi_cnt <= hi_cnt + 16'h0001;
      end
      if (!lvl && pin_q)
        last_high <= hi_cnt;
    end
  end
endmodule

// file: sim/pdg_top_tb.sv
// Self-checking bench of the duty-cycle generator over APB.
`timescale 1ns/1ps
`include "pdg_defs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module pdg_top_tb;
  logic core_clk;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pulse_output_pin;
  logic pulse_output_en;
  logic [15:0] last_high;
  logic [15:0] last_period;
  logic [31:0] rd;
  logic err;
  int miscompares = 0;
  int check_count = 0;
  int lows;

  pdg_top u_pdg_top (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_output_pin(pulse_output_pin), .pulse_output_en(pulse_output_en));
  pdg_pin_monitor u_pdg_pin_monitor (.core_clk(core_clk), .srst(srst), .pin(pulse_output_pin),
    .en(pulse_output_en), .last_high(last_high), .last_period(last_period));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================
  // APB master
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Period, then duty, then tctl, the order software must keep
  task automatic cfg(input logic [7:0] per, input logic [9:0] duty, input logic [6:0] tctl);
    apb(1'b1, `PDG_IDX_PERIOD, {24'h0, per});
    apb(1'b1, `PDG_IDX_MASTER, {24'h0, duty[9:2]});
    apb(1'b1, `PDG_IDX_MODE, {26'h0, duty[1:0], 4'hc});
    apb(1'b1, `PDG_IDX_TCTL, {25'h0, tctl});
  endtask

  task automatic count_lows(input int n);
    lows = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      if (pulse_output_pin !== 1'b1)
        lows++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values and an unmapped read
    apb(1'b0, `PDG_IDX_PERIOD, 32'h0);
    `CHK("period reset", 32'h0000_00ff, rd)
    apb(1'b0, `PDG_IDX_TIMER, 32'h0);
    `CHK("timer reset", 32'h0, rd)
    apb(1'b0, `PDG_IDX_TCTL, 32'h0);
    `CHK("tctl reset", 32'h0, rd)
    apb(1'b0, `PDG_IDX_MODE, 32'h0);
    `CHK("mode reset", 32'h0, rd)
    `CHK("pin enable reset", 1'b0, pulse_output_en)
    apb(1'b0, 10'h3ff, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset done");
    // Factor 1, period 3, duty 6
    cfg(8'h03, 10'd6, 7'h04);
    repeat (64) @(posedge core_clk);
    `CHK("pin enable", 1'b1, pulse_output_en)
    `CHK("high f1", 16'd6, last_high)
    `CHK("period f1", 16'd16, last_period)
    apb(1'b0, `PDG_IDX_STATUS, 32'h0);
    `CHK("match flag", 32'h1, rd)
    $display("test basic done");
    // Buffered reload of a duty with nonzero low bits
    apb(1'b1, `PDG_IDX_TCTL, 32'h0);
    apb(1'b1, `PDG_IDX_MASTER, 32'h2);
    apb(1'b1, `PDG_IDX_MODE, 32'h2c);
    apb(1'b0, `PDG_IDX_SLAVE, 32'h0);
    `CHK("slave before match", 32'h1, rd)
    apb(1'b1, `PDG_IDX_TCTL, 32'h4);
    repeat (64) @(posedge core_clk);
    apb(1'b0, `PDG_IDX_SLAVE, 32'h0);
    `CHK("slave after match", 32'h2, rd)
    `CHK("high duty 10", 16'd10, last_high)
    apb(1'b1, `PDG_IDX_SLAVE, 32'h55);
    apb(1'b0, `PDG_IDX_SLAVE, 32'h0);
    `CHK("slave read only", 32'h2, rd)
    $display("test buffer done");
    // Prescale factors 4 and 16
    cfg(8'h03, 10'd6, 7'h05);
    repeat (200) @(posedge core_clk);
    `CHK("high f4", 16'd24, last_high)
    `CHK("period f4", 16'd64, last_period)
    cfg(8'h03, 10'd6, 7'h06);
    repeat (800) @(posedge core_clk);
    `CHK("high f16", 16'd96, last_high)
    `CHK("period f16", 16'd256, last_period)
    $display("test prescale done");
    // Duty above period never clears; zero duty never rises
    cfg(8'h03, 10'h3ff, 7'h04);
    // The prescaler may first have to wrap from its divide-by-16 count
    repeat (100) @(posedge core_clk);
    count_lows(48);
    `CHK("lows long duty", 0, lows)
    cfg(8'h03, 10'h000, 7'h04);
    repeat (40) @(posedge core_clk);
    count_lows(48);
    `CHK("lows zero duty", 48, lows)
    $display("test limits done");
    finish_test();
  end
endmodule
